// ### slp_regs.svh
// Purpose: constants of the sleep-mode controller
// Assumes: one clock, sys_clk at 250 MHz
// Notes:   mode indices run from lightest to deepest
`ifndef SLP_REGS_SVH
`define SLP_REGS_SVH
`define SLP_MODE_IDLE     8'h00
`define SLP_MODE_FROZEN   8'h01
`define SLP_MODE_STANDBY  8'h02
`define SLP_MODE_STOP     8'h03
`define SLP_MODE_BGOFF    8'h04
`define SLP_MODE_STATIC   8'h05
`define SLP_MODE_LAST     8'h05
`define SLP_OP_W          8
`endif

// ### slp_pkg.sv
// Purpose: types shared by both ends of the sleep link
// Assumes: slp_regs.svh holds the numeric constants
// Notes:   states are one-hot with codes written out
package slp_pkg;
  // sleep controller states
  typedef enum logic [2:0] {
    SLP_RUN   = 3'b001,
    SLP_DRAIN = 3'b010,
    SLP_SLEEP = 3'b100
  } slp_state_type;
  // cpu end states
  typedef enum logic [3:0] {
    SLP_C_RUN   = 4'b0001,
    SLP_C_ENTER = 4'b0010,
    SLP_C_SLEEP = 4'b0100,
    SLP_C_READ  = 4'b1000
  } slp_cpu_state_type;
endpackage

// ### slp_if.sv
// Purpose: link between cpu core and sleep controller
// Assumes: both ends on sys_clk
// Notes:   request lines are levels held by the cpu end
`timescale 1ns/100ps
interface slp_if;
  logic       sleep_req;          // cpu asks for sleep
  logic [7:0] sleep_mode_operand; // mode index of the instruction
  logic       user_mode;          // instruction ran in user mode
  logic       cpu_safe;           // cpu own bus operations done
  logic       priv_violation;     // pulse: sleep refused, exception
  logic       halted;             // cpu clock stopped
  logic       resume;             // pulse: sleep over or request dropped
  logic       resume_isr;         // with resume: service routine runs
  logic       pb_rd_req;          // peripheral_bus read held by cpu
  logic       pb_rd_ack;          // pulse: read done, bus drained
  modport dev (input sleep_req, sleep_mode_operand, user_mode, cpu_safe, pb_rd_req,
               output priv_violation, halted, resume, resume_isr, pb_rd_ack);
  modport cpu (output sleep_req, sleep_mode_operand, user_mode, cpu_safe, pb_rd_req,
               input priv_violation, halted, resume, resume_isr, pb_rd_ack);
endinterface

// ### slp_wake_sel.sv
// Purpose: per-mode wake source filter
// Assumes: sources are synchronous levels except async external irq
// Notes:   a source whose module is unclocked in a mode is not listed
`timescale 1ns/100ps
`include "slp_regs.svh"
module slp_wake_sel
  import slp_pkg::*;
(
  input  wire logic [7:0] mode,        // latched sleep mode
  input  wire logic       irq_hsb,     // irq from high_speed_system_bus modules
  input  wire logic       irq_pb,      // irq from peripheral_bus modules
  input  wire logic       rtc_wake,    // rtc wake-up line
  input  wire logic       ext_irq,     // external irq, synchronous mode
  input  wire logic       ext_irq_async, // external irq, asynchronous mode
  input  wire logic       reset_pin,   // external reset pin request
  output logic            wake,        // leave sleep now
  output logic            intc_on      // interrupt controller clocked
);
  // decode which sources can still fire in each mode
  always_comb begin
    unique case (mode)
      `SLP_MODE_IDLE: begin
        wake    = irq_hsb | irq_pb | rtc_wake | ext_irq | ext_irq_async;
        intc_on = 1'b1;
      end
      `SLP_MODE_FROZEN: begin
        // hsb modules are unclocked so their irqs cannot fire
        wake    = irq_pb | rtc_wake | ext_irq | ext_irq_async;
        intc_on = 1'b1;
      end
      `SLP_MODE_STANDBY: begin
        wake    = rtc_wake | ext_irq | ext_irq_async;
        intc_on = 1'b0;
      end
      `SLP_MODE_STOP, `SLP_MODE_BGOFF: begin
        wake    = rtc_wake | ext_irq | ext_irq_async | reset_pin;
        intc_on = 1'b0;
      end
      `SLP_MODE_STATIC: begin
        // no oscillator runs, only the asynchronous irq and the reset pin survive
        wake    = ext_irq_async | reset_pin;
        intc_on = 1'b0;
      end
      default: begin
        wake    = 1'b1;
        intc_on = 1'b1;
      end
    endcase
  end
endmodule

// ### slp_ctrl.sv
// Purpose: sleep-mode controller, device end of the sleep link
// Assumes: srst synchronous active high; pb_pending from the bus bridge
// Notes:   clock and analog enables are registered from the next state, so they change together with state
// Function
// - pins come up as inputs after reset
// - all clock domains run when awake
// - 8-bit operand selects the sleep mode
// - user-mode sleep raises privilege violation instead
// - stopped domains halt regardless of masks
// - enabled, clocked interrupt ends sleep
// - mode 0: only cpu clock stops
// - mode 1: cpu and hsb stop, pb irq wakes
// - mode 2: sync clocks stop, oscillators run
// - mode 3: also main oscillators, plls stop
// - mode 4: also bandgap and brownout off
// - mode 5: all oscillators off, async wake
// - cpu halts only after its bus operations
// - software avoids cross-domain transfers during transitions
// - software stops hsb masters before deeper modes
// - pb read stalls until pb writes drain
// - software disables externally wired modules first
// - rtc wake with intc off (modes 2 to 4) resumes after sleep, no isr
`timescale 1ns/100ps
`include "slp_regs.svh"
module slp_ctrl
  import slp_pkg::*;
(
  input  wire logic sys_clk,             // system clock
  input  wire logic srst,                // synchronous reset
  slp_if.dev        lnk,                 // link to the cpu end
  input  wire logic pins_configured,     // software has set up the pins
  input  wire logic pb_pending,          // a peripheral_bus write is in flight
  input  wire logic osc32_enable,        // software enable of the 32 kHz osc
  input  wire logic irq_hsb,             // irq from high_speed_system_bus modules
  input  wire logic irq_pb,              // irq from peripheral_bus modules
  input  wire logic rtc_wake,            // rtc wake-up line
  input  wire logic ext_irq,             // external irq, synchronous mode
  input  wire logic ext_irq_async,       // external irq, asynchronous mode
  input  wire logic reset_pin,           // external reset pin request
  output logic      pins_force_input,    // all multiplexed pins held as inputs
  output logic      clk_en_cpu,          // cpu clock domain runs
  output logic      clk_en_hsb,          // high_speed_system_bus domain runs
  output logic      clk_en_pb,           // peripheral_bus domain runs
  output logic      osc_main_en,         // main oscillators 0 and 1 run
  output logic      pll_en,              // both plls run
  output logic      osc32_en,            // 32 kHz oscillator runs
  output logic      rc_osc_en,           // rc oscillator runs
  output logic      bandgap_en,          // bandgap reference on
  output logic      brownout_detector_en // brownout_detector on
);
  slp_state_type state_q, state_d;       // controller state
  logic [7:0]    mode_q, mode_d;         // latched mode index
  logic          priv_q, priv_d;         // privilege violation pulse
  logic          resume_q, resume_d;     // resume pulse
  logic          isr_q, isr_d;           // resume runs a service routine
  logic          ack_q, ack_d;           // pb read answer pulse
  logic          pins_q, pins_d;         // pins held as inputs
  logic [8:0]    en_q, en_d;             // packed clock and analog enables
  logic          halt_q, halt_d;         // cpu clock stopped
  logic          wake;                   // filtered wake for the latched mode
  logic          intc_on;                // interrupt controller clocked
  logic          accept;                 // new sleep request seen this cycle

  // supported mode test, used by request decode
  function automatic logic mode_ok(input logic [7:0] m);
    mode_ok = (m <= `SLP_MODE_LAST);
  endfunction

  slp_wake_sel u_wake (
    .mode          (mode_q),
    .irq_hsb       (irq_hsb),
    .irq_pb        (irq_pb),
    .rtc_wake      (rtc_wake),
    .ext_irq       (ext_irq),
    .ext_irq_async (ext_irq_async),
    .reset_pin     (reset_pin),
    .wake          (wake),
    .intc_on       (intc_on)
  );

  // a held request is ignored while our own answer pulse is out,
  // otherwise the cpu end would be taken twice for one instruction
  assign accept = lnk.sleep_req & ~resume_q & ~priv_q;

  // sleep sequencing
  always_comb begin
    state_d  = state_q;
    mode_d   = mode_q;
    priv_d   = 1'b0;
    resume_d = 1'b0;
    isr_d    = isr_q;
    unique case (state_q)
      SLP_RUN: begin
        if (accept) begin
          if (lnk.user_mode) begin
            priv_d = 1'b1;
          end else if (!mode_ok(lnk.sleep_mode_operand)) begin
            resume_d = 1'b1;                     // unsupported: keep running
            isr_d    = 1'b0;
          end else begin
            mode_d  = lnk.sleep_mode_operand;
            state_d = SLP_DRAIN;
          end
        end
      end
      SLP_DRAIN: begin
        // wait for the cpu to park its bus traffic and pb writes to land
        if (lnk.cpu_safe && !pb_pending) begin
          state_d = SLP_SLEEP;
        end
      end
      SLP_SLEEP: begin
        if (wake) begin
          state_d  = SLP_RUN;
          resume_d = 1'b1;
          // rtc wake with intc off returns past the sleep instruction
          isr_d    = intc_on;
        end
      end
    endcase
  end

  // pb read stall and pin hold
  always_comb begin
    ack_d  = lnk.pb_rd_req & ~pb_pending & ~ack_q;
    pins_d = pins_q & ~pins_configured;
  end

  // clock and analog enables from the mode being slept in
  always_comb begin
    en_d   = '1;                                 // all running when awake
    halt_d = 1'b0;
    if (state_d == SLP_SLEEP) begin
      halt_d  = 1'b1;
      en_d[0] = 1'b0;                            // cpu, masks ignored
      if (mode_d >= `SLP_MODE_FROZEN) begin
        en_d[1] = 1'b0;                          // hsb
      end
      if (mode_d >= `SLP_MODE_STANDBY) begin
        en_d[2] = 1'b0;                          // pb
      end
      if (mode_d >= `SLP_MODE_STOP) begin
        en_d[3] = 1'b0;                          // main oscillators
        en_d[4] = 1'b0;                          // plls
      end
      if (mode_d >= `SLP_MODE_BGOFF) begin
        en_d[7] = 1'b0;                          // bandgap
        en_d[8] = 1'b0;                          // brownout_detector
      end
      if (mode_d >= `SLP_MODE_STATIC) begin
        en_d[5] = 1'b0;                          // 32 kHz
        en_d[6] = 1'b0;                          // rc
      end
    end
    en_d[5] = en_d[5] & osc32_enable;            // 32 kHz only when enabled
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q  <= SLP_RUN;
      mode_q   <= 8'h00;
      priv_q   <= 1'b0;
      resume_q <= 1'b0;
      isr_q    <= 1'b0;
      ack_q    <= 1'b0;
      pins_q   <= 1'b1;
      en_q     <= 9'h1FF;
      halt_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      priv_q   <= priv_d;
      resume_q <= resume_d;
      isr_q    <= isr_d;
      ack_q    <= ack_d;
      pins_q   <= pins_d;
      en_q     <= en_d;
      halt_q   <= halt_d;
    end
  end

  // outputs
  assign lnk.priv_violation   = priv_q;
  assign lnk.resume           = resume_q;
  assign lnk.resume_isr       = isr_q;
  assign lnk.pb_rd_ack        = ack_q;
  assign lnk.halted           = halt_q;
  assign pins_force_input     = pins_q;
  assign clk_en_cpu           = en_q[0];
  assign clk_en_hsb           = en_q[1];
  assign clk_en_pb            = en_q[2];
  assign osc_main_en          = en_q[3];
  assign pll_en               = en_q[4];
  assign osc32_en             = en_q[5] & osc32_enable;
  assign rc_osc_en            = en_q[6];
  assign bandgap_en           = en_q[7];
  assign brownout_detector_en = en_q[8];
endmodule

// ### slp_cpu.sv
// Purpose: cpu core end of the sleep link
// Assumes: commands are one-cycle pulses from the pipeline
// Notes:   a command arriving while busy is dropped
`timescale 1ns/100ps
`include "slp_regs.svh"
module slp_cpu
  import slp_pkg::*;
(
  input  wire logic       sys_clk,           // system clock
  input  wire logic       srst,              // synchronous reset
  slp_if.cpu              lnk,               // link to the controller
  input  wire logic       cmd_sleep,         // sleep instruction pulse
  input  wire logic [7:0] cmd_mode,          // its sleep_mode_operand
  input  wire logic       cmd_user,          // executed in user mode
  input  wire logic       cmd_pb_read,       // peripheral_bus read pulse
  input  wire logic       bus_busy,          // cpu has bus operations open
  input  wire logic       hsb_masters_stopped, // all hsb masters idle
  output logic            busy,              // cpu end not in run
  output logic            exc_priv,          // privilege exception pulse
  output logic            woke,              // resumed pulse
  output logic            woke_isr,          // service routine runs on wake
  output logic            read_done          // pb read finished pulse
);
  slp_cpu_state_type state_q, state_d;       // cpu end state
  logic [7:0]        mode_q, mode_d;         // held operand
  logic              user_q, user_d;         // held privilege level
  logic              exc_q, exc_d;           // exception pulse
  logic              woke_q, woke_d;         // wake pulse
  logic              isr_q, isr_d;           // wake runs a routine
  logic              rd_q, rd_d;             // read done pulse

  // command handling
  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    user_d  = user_q;
    exc_d   = 1'b0;
    woke_d  = 1'b0;
    isr_d   = isr_q;
    rd_d    = 1'b0;
    unique case (state_q)
      SLP_C_RUN: begin
        if (cmd_sleep) begin
          mode_d  = cmd_mode;
          user_d  = cmd_user;
          state_d = SLP_C_ENTER;
        end else if (cmd_pb_read) begin
          state_d = SLP_C_READ;
        end
      end
      SLP_C_ENTER: begin
        if (lnk.priv_violation) begin
          exc_d   = 1'b1;
          state_d = SLP_C_RUN;
        end else if (lnk.resume) begin
          woke_d  = 1'b1;                    // mode refused, run on
          isr_d   = 1'b0;
          state_d = SLP_C_RUN;
        end else if (lnk.halted) begin
          state_d = SLP_C_SLEEP;
        end
      end
      SLP_C_SLEEP: begin
        if (lnk.resume) begin
          woke_d  = 1'b1;
          isr_d   = lnk.resume_isr;
          state_d = SLP_C_RUN;
        end
      end
      SLP_C_READ: begin
        if (lnk.pb_rd_ack) begin
          rd_d    = 1'b1;                    // stalled until drained
          state_d = SLP_C_RUN;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= SLP_C_RUN;
      mode_q  <= 8'h00;
      user_q  <= 1'b0;
      exc_q   <= 1'b0;
      woke_q  <= 1'b0;
      isr_q   <= 1'b0;
      rd_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      user_q  <= user_d;
      exc_q   <= exc_d;
      woke_q  <= woke_d;
      isr_q   <= isr_d;
      rd_q    <= rd_d;
    end
  end

  // request held until answered; deeper modes wait for hsb masters,
  // so no hsb transfer straddles the clock stop
  assign lnk.sleep_req          = (state_q == SLP_C_ENTER) &
                                  ((mode_q == `SLP_MODE_IDLE) | hsb_masters_stopped | user_q);
  assign lnk.sleep_mode_operand = mode_q;
  assign lnk.user_mode          = user_q;
  assign lnk.cpu_safe           = ~bus_busy;
  assign lnk.pb_rd_req          = (state_q == SLP_C_READ);
  assign busy                   = (state_q != SLP_C_RUN);
  assign exc_priv               = exc_q;
  assign woke                   = woke_q;
  assign woke_isr               = isr_q;
  assign read_done              = rd_q;
endmodule

// ### slp_checker.sv
// Purpose: watches the sleep link between the cpu end and the controller
// Assumes: one clock, srst synchronous active high
// Notes:   sees only link signals; drain waits are bounded at 40 cycles
`timescale 1ns/100ps
module slp_checker (
  input wire logic       sys_clk,            // system clock
  input wire logic       srst,               // synchronous reset
  input wire logic       sleep_req,          // cpu asks for sleep
  input wire logic [7:0] sleep_mode_operand, // mode index
  input wire logic       user_mode,          // request from user mode
  input wire logic       cpu_safe,           // cpu bus operations done
  input wire logic       priv_violation,     // refusal pulse
  input wire logic       halted,             // controller sleeping
  input wire logic       resume,             // wake pulse
  input wire logic       resume_isr,         // service routine on wake
  input wire logic       pb_rd_req,          // peripheral_bus read held
  input wire logic       pb_rd_ack           // read done pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // user request answered by a refusal one cycle later
  property p_user_refused; $rose(sleep_req) && user_mode |-> ##1 priv_violation; endproperty
  a_user_refused: assert property (p_user_refused) else $error("user sleep not refused");
  // a refused request keeps halted low for three cycles
  property p_user_no_halt; $rose(sleep_req) && user_mode |-> !halted [*3]; endproperty
  a_user_no_halt: assert property (p_user_no_halt) else $error("user sleep halted");
  // indices above the deepest mode are answered at once, no sleep
  property p_bad_mode;
    $rose(sleep_req) && !user_mode && sleep_mode_operand > 8'h05 |-> ##1 (resume && !resume_isr);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("unsupported mode not answered");
  // a supported index reaches sleep once draining is done
  property p_good_mode; $rose(sleep_req) && !user_mode && sleep_mode_operand <= 8'h05 |-> ##[1:40] halted; endproperty
  a_good_mode: assert property (p_good_mode) else $error("supported mode never slept");
  // halt only on an edge that saw the cpu safe
  property p_safe_halt; $rose(halted) |-> $past(cpu_safe); endproperty
  a_safe_halt: assert property (p_safe_halt) else $error("halt while cpu bus busy");
  // leaving sleep always comes with the resume pulse
  property p_wake_resume; $fell(halted) |-> resume; endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("halt dropped without resume");
  // only modes with a live interrupt controller run a service routine
  property p_isr; $fell(halted) |-> resume_isr == (sleep_mode_operand <= 8'h01); endproperty
  a_isr: assert property (p_isr) else $error("wrong service routine flag");
  // answers are single-cycle pulses
  property p_pulse; (priv_violation || resume || pb_rd_ack) |=> !(priv_violation || resume || pb_rd_ack); endproperty
  a_pulse: assert property (p_pulse) else $error("answer pulse too long");
  // read answer only for a read that was held
  property p_ack_req; pb_rd_ack |-> $past(pb_rd_req); endproperty
  a_ack_req: assert property (p_ack_req) else $error("read ack without request");
  c_sleep: cover property ($rose(halted));
  c_priv: cover property (priv_violation);
  c_isr: cover property (resume && resume_isr);
  c_ack: cover property (pb_rd_ack);
endmodule

// ### tb_sleep_mode_controller.sv
// Purpose: drives both ends of the sleep link through every mode
// Assumes: inputs change at the falling edge
// Notes:   expectations come from a per-mode table of enables
`timescale 1ns/100ps
module tb_sleep_mode_controller;
  import slp_pkg::*;
  logic       sys_clk, srst;          // clock and reset
  logic       pins_configured;        // software pin setup done
  logic       pb_pending;             // peripheral_bus write in flight
  logic [5:0] wake_in;                // hsb, pb, rtc, ext, async, reset pin
  logic       cmd_sleep, cmd_user;    // sleep instruction
  logic [7:0] cmd_mode;               // its operand
  logic       cmd_pb_read, bus_busy;  // read pulse, open bus work
  logic       hsb_stop;               // hsb masters idle
  logic       pfi, busy, exc_priv, woke, woke_isr, read_done;
  logic [8:0] en;                     // cpu hsb pb main pll 32k rc bg bod
  int         bad_count, comparisons, cycles;
  slp_if slp_if_i ();
  slp_ctrl slp_ctrl_i (.sys_clk(sys_clk), .srst(srst), .lnk(slp_if_i.dev), .pins_configured(pins_configured),
    .pb_pending(pb_pending), .osc32_enable(1'b1), .irq_hsb(wake_in[5]), .irq_pb(wake_in[4]),
    .rtc_wake(wake_in[3]), .ext_irq(wake_in[2]), .ext_irq_async(wake_in[1]), .reset_pin(wake_in[0]),
    .pins_force_input(pfi), .clk_en_cpu(en[8]), .clk_en_hsb(en[7]), .clk_en_pb(en[6]), .osc_main_en(en[5]),
    .pll_en(en[4]), .osc32_en(en[3]), .rc_osc_en(en[2]), .bandgap_en(en[1]), .brownout_detector_en(en[0]));
  slp_cpu slp_cpu_i (.sys_clk(sys_clk), .srst(srst), .lnk(slp_if_i.cpu), .cmd_sleep(cmd_sleep),
    .cmd_mode(cmd_mode), .cmd_user(cmd_user), .cmd_pb_read(cmd_pb_read), .bus_busy(bus_busy),
    .hsb_masters_stopped(hsb_stop), .busy(busy), .exc_priv(exc_priv), .woke(woke), .woke_isr(woke_isr),
    .read_done(read_done));
  slp_checker slp_checker_i (.sys_clk(sys_clk), .srst(srst), .sleep_req(slp_if_i.sleep_req),
    .sleep_mode_operand(slp_if_i.sleep_mode_operand), .user_mode(slp_if_i.user_mode),
    .cpu_safe(slp_if_i.cpu_safe), .priv_violation(slp_if_i.priv_violation), .halted(slp_if_i.halted),
    .resume(slp_if_i.resume), .resume_isr(slp_if_i.resume_isr), .pb_rd_req(slp_if_i.pb_rd_req),
    .pb_rd_ack(slp_if_i.pb_rd_ack));
  // clock and cycle ceiling; the whole run needs well under a thousand cycles
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // single-bit result
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // enable vector result
  task automatic chk_en(input logic [8:0] exp, input string msg);
    comparisons++;
    if (en !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h", $time, msg, en);
    end
  endtask
  // enables left running in each sleep mode, deeper modes stop more
  function automatic logic [8:0] exp_en(input logic [7:0] m);
    case (m)
      8'h00:   return 9'h0FF;
      8'h01:   return 9'h07F;
      8'h02:   return 9'h03F;
      8'h03:   return 9'h00F;
      8'h04:   return 9'h00C;
      default: return 9'h000;
    endcase
  endfunction
  // bounded wait for halted, woke, read_done or exc_priv; pulses are caught since we look every cycle
  task automatic wait_hi(input int s, input int lim, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++) begin
      @(negedge sys_clk);
      case (s)
        0:       ok = (slp_if_i.halted === 1'b1);
        1:       ok = (woke === 1'b1);
        2:       ok = (read_done === 1'b1);
        default: ok = (exc_priv === 1'b1);
      endcase
    end
  endtask
  // one sleep instruction; hold 1 keeps bus busy, 2 keeps a pb write pending, 3 keeps hsb masters running
  // no externally wired module is modelled, so none is left active over a sleep
  task automatic issue(input logic [7:0] m, input logic u, input int hold);
    repeat (3) @(negedge sys_clk);
    cmd_sleep = 1'b1;
    cmd_mode = m;
    cmd_user = u;
    bus_busy = (hold == 1);
    pb_pending = (hold == 2);
    hsb_stop = (hold != 3);
    @(negedge sys_clk);
    cmd_sleep = 1'b0;
    if (hold != 0) begin
      repeat (6) @(negedge sys_clk);
      chk_bit(slp_if_i.halted, 1'b0, "halted before drain");
      bus_busy = 1'b0;
      pb_pending = 1'b0;
      hsb_stop = 1'b1;
    end
  endtask
  // full sleep and wake; bad_w must not wake, good_w must
  task automatic sleep_cycle(input logic [7:0] m, input logic [5:0] bad_w, good_w, input int hold);
    logic ok;
    issue(m, 1'b0, hold);
    wait_hi(0, 20, ok);
    chk_bit(ok, 1'b1, "no halt");
    @(negedge sys_clk);
    chk_en(exp_en(m), "sleep enables");
    wake_in = bad_w;
    repeat (4) @(negedge sys_clk);
    chk_bit(slp_if_i.halted, 1'b1, "woken by unclocked source");
    wake_in = good_w;
    wait_hi(1, 10, ok);
    chk_bit(ok, 1'b1, "no wake");
    chk_bit(woke_isr, m <= 8'h01, "service routine flag");
    chk_bit(busy, 1'b0, "cpu end busy after wake");
    wake_in = 6'h00;
    @(negedge sys_clk);
    chk_en(9'h1FF, "awake enables");
  endtask
  initial begin
    logic ok;
    srst = 1'b1;
    {pins_configured, pb_pending, wake_in, cmd_sleep, cmd_user, cmd_mode} = '0;
    {cmd_pb_read, bus_busy} = 2'b00;
    hsb_stop = 1'b1;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    chk_bit(pfi, 1'b1, "pins not inputs");
    chk_en(9'h1FF, "reset enables");
    pins_configured = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit(pfi, 1'b0, "pins still forced");
    sleep_cycle(8'h00, 6'h00, 6'h20, 0);
    sleep_cycle(8'h01, 6'h20, 6'h10, 3);
    sleep_cycle(8'h02, 6'h10, 6'h08, 1);
    sleep_cycle(8'h03, 6'h10, 6'h01, 2);
    sleep_cycle(8'h04, 6'h10, 6'h04, 0);
    sleep_cycle(8'h05, 6'h08, 6'h02, 0);
    issue(8'h02, 1'b1, 0);
    wait_hi(3, 10, ok);
    chk_bit(ok, 1'b1, "no privilege exception");
    chk_bit(slp_if_i.halted, 1'b0, "user sleep halted");
    for (int k = 0; k < 2; k++) begin
      issue(k == 0 ? 8'h06 : 8'hFF, 1'b0, 0);
      wait_hi(1, 10, ok);
      chk_bit(ok, 1'b1, "unsupported mode not answered");
      chk_bit(woke_isr, 1'b0, "unsupported mode service flag");
      chk_en(9'h1FF, "unsupported mode stopped clocks");
    end
    repeat (3) @(negedge sys_clk);
    pb_pending = 1'b1;
    cmd_pb_read = 1'b1;
    @(negedge sys_clk);
    cmd_pb_read = 1'b0;
    wait_hi(2, 6, ok);
    chk_bit(ok, 1'b0, "read done with write pending");
    pb_pending = 1'b0;
    wait_hi(2, 6, ok);
    chk_bit(ok, 1'b1, "read never done");
    report_and_stop();
  end
endmodule
